// file: csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH
// Register byte offsets; the buffer occupies 0x80..0xFC, one byte per word.
`define CSP_OFS_MODE 8'h00
`define CSP_OFS_STAT 8'h04
`define CSP_OFS_TRIG 8'h08
`define CSP_OFS_DIV 8'h0C
`define CSP_OFS_END 8'h10
`define CSP_OFS_GAP 8'h14
`define CSP_OFS_PTR 8'h18
`define CSP_OFS_SHD 8'h1C
// Mode field positions.
`define CSP_B_EN 0
`define CSP_B_AUTO 1
`define CSP_B_RPT 2
`define CSP_B_ORD 3
`define CSP_B_RXE 4
`define CSP_B_TXE 5
// Trigger and status field positions.
`define CSP_B_START 0
`define CSP_B_STOP 1
`define CSP_B_TIP 0
// Reset values.
`define CSP_MODE_RST 6'h00
`define CSP_DIV_RST 8'h03
`define CSP_END_RST 5'h00
`define CSP_GAP_RST 6'h00
`define CSP_PTR_RST 5'h00
// Last bit index of a byte and bus responses.
`define CSP_LAST_BIT 4'h7
`define CSP_RESP_OK 2'h0
`define CSP_RESP_ERR 2'h2
`endif

// file: csp_pkg.sv
package csp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT,
    ST_STORE,
    ST_GAP
  } csp_state_t;
endpackage : csp_pkg

// file: csp_serial_port.sv
// Notes on behaviour
// - Enabled, auto off: writing shift data sends that byte.
// - Out and sample on clock fall; sampled bit shifts in on next rise.
// - Send and receive together; receive-only needs a dummy write.
// - Single-byte mode raises the done pulse after one byte.
// - Repeat bit is ignored in single-byte mode.
// - Bytes are 8 bits; order bit 0 MSB first, 1 LSB first.
// - Order reversal sits on the bus path; shifting stays fixed.
// - Start only if already enabled and idle; late enable starts nothing.
// - After 8 bits the clock stops and the interbyte gap begins.
// - Auto mode moves up to 32 buffer bytes unattended.
// - Load byte at pointer, send, store reply there, then step pointer.
// - Auto transfer runs until the end pointer is reached, then stops.
// - Pointer clears at the end; repeat bit starts over.
// - Auto ends on disable, on stop after the byte, or at range end.
// - Every ending pulses done except the one caused by disable.
// - Interbyte gap from interval register; CPU buffer clashes lengthen it.
// - Serial output is low whenever busy is clear.
// - Store received byte and step pointer before loading next byte.
// - Gap is 0 to 63 serial clocks; done fires after it.
// - Repeat mode gives no done pulse at range end and resends from zero.
`include "csp_defines.svh"
module csp_serial_port import csp_pkg::*; #(
  parameter logic [7:0] DIV_RST = `CSP_DIV_RST
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link.
  output logic serial_clock_line,
  output logic serial_out_line,
  input wire logic serial_in_line,
  // Completion event.
  output logic transfer_done_irq
);

  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [5:0] mode_ff;
  logic [7:0] div_ff;
  logic [4:0] end_ff, ptr_ff;
  logic [5:0] gap_ff;
  logic tip_ff, nxt_tip, stop_ff, last_ff, irq_ff;
  csp_state_t state_ff;
  logic [7:0] shreg_ff, half_cnt_ff;
  logic [3:0] bit_cnt_ff;
  logic [6:0] gap_cnt_ff;
  logic rxbit_ff, sck_ff, sout_ff, sin_s1_ff, sin_s2_ff;
  logic [7:0] mem [0:31];
  logic wr_go, rd_go, wr_lo, wr_buf, rd_buf, cpu_buf;
  logic [7:0] wword, rword;
  logic en, auto_m, rpt, ord, rxe, txe;
  logic tick, fall, rise, gap_done, finish, ending;
  logic start_single, start_auto, wr_shd, wr_trig;

  function automatic logic [7:0] rev8(input logic [7:0] d);
    rev8 = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
  endfunction : rev8

  // Bus handshakes: a write needs address and data together, one at a time.
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rd_go = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Address decode; only byte lane 0 carries register data.
  assign wword = {s_axi_awaddr[7:2], 2'b00};
  assign rword = {s_axi_araddr[7:2], 2'b00};
  assign wr_lo = wr_go & s_axi_wstrb[0];
  assign wr_buf = wr_lo & s_axi_awaddr[7];
  assign rd_buf = rd_go & s_axi_araddr[7];
  assign cpu_buf = wr_buf | rd_buf;
  assign wr_shd = wr_lo & (wword == `CSP_OFS_SHD);
  assign wr_trig = wr_lo & (wword == `CSP_OFS_TRIG);

  // Mode fields.
  assign en = mode_ff[`CSP_B_EN];
  assign auto_m = mode_ff[`CSP_B_AUTO];
  assign rpt = mode_ff[`CSP_B_RPT];
  assign ord = mode_ff[`CSP_B_ORD];
  assign rxe = mode_ff[`CSP_B_RXE];
  assign txe = mode_ff[`CSP_B_TXE];

  // Start conditions; the enable must already be set when the write lands.
  assign start_single = wr_shd & en & ~auto_m & ~tip_ff;
  assign start_auto = wr_trig & s_axi_wdata[`CSP_B_START] & en & auto_m & ~tip_ff;

  // Serial clock phases and the interbyte gap in half periods.
  assign tick = (half_cnt_ff == div_ff);
  assign fall = (state_ff == ST_SHIFT) & tick & sck_ff;
  assign rise = (state_ff == ST_SHIFT) & tick & ~sck_ff;
  assign gap_done = (gap_cnt_ff == {gap_ff, 1'b0});
  // Single-byte mode always ends after its byte, whatever the repeat bit says.
  assign finish = ~auto_m | last_ff | stop_ff;
  assign ending = en & (state_ff == ST_GAP) & gap_done & finish;

  // Busy flag, computed ahead so the output line can fall in the same edge.
  always_comb begin
    nxt_tip = tip_ff;
    if (!en) begin
      nxt_tip = 1'b0;
    end else if (start_single | start_auto) begin
      nxt_tip = 1'b1;
    end else if (ending) begin
      nxt_tip = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tip_ff <= 1'b0;
    end else begin
      tip_ff <= nxt_tip;
    end
  end

  // Done pulse; a disable never produces one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ending;
    end
  end
  assign transfer_done_irq = irq_ff;

  // Sequencer. CPU buffer traffic has priority, so load and store wait on it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else if (!en) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_single) begin
            state_ff <= ST_SHIFT;
          end else if (start_auto) begin
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (!cpu_buf) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rise && bit_cnt_ff == `CSP_LAST_BIT) begin
            state_ff <= auto_m ? ST_STORE : ST_GAP;
          end
        end
        ST_STORE: begin
          if (!cpu_buf) begin
            state_ff <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_done) begin
            state_ff <= finish ? ST_IDLE : ST_LOAD;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Divider for half serial clock periods, running only while shifting or waiting.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_ff <= 8'h00;
    end else if (state_ff == ST_SHIFT || state_ff == ST_GAP) begin
      half_cnt_ff <= tick ? 8'h00 : half_cnt_ff + 8'h01;
    end else begin
      half_cnt_ff <= 8'h00;
    end
  end

  // Gap counter; two half periods make one transfer clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_ff <= 7'h00;
    end else if (state_ff == ST_GAP) begin
      if (tick && !gap_done) begin
        gap_cnt_ff <= gap_cnt_ff + 7'h01;
      end
    end else begin
      gap_cnt_ff <= 7'h00;
    end
  end

  // Serial clock idles high and stops once the byte is done.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_ff <= 1'b1;
    end else if (!en || state_ff != ST_SHIFT) begin
      sck_ff <= 1'b1;
    end else if (tick) begin
      sck_ff <= ~sck_ff;
    end
  end
  assign serial_clock_line = sck_ff;

  // Bit counter counts rising edges within a byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 4'h0;
    end else if (state_ff != ST_SHIFT) begin
      bit_cnt_ff <= 4'h0;
    end else if (rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // Input synchroniser; only the second stage is sampled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_s1_ff <= 1'b0;
      sin_s2_ff <= 1'b0;
    end else begin
      sin_s1_ff <= serial_in_line;
      sin_s2_ff <= sin_s1_ff;
    end
  end

  // Received bit caught at the falling edge, held for the following rise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxbit_ff <= 1'b0;
    end else if (fall) begin
      rxbit_ff <= sin_s2_ff;
    end
  end

  // Output line; low whenever idle, blanked in auto mode without transmit enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_ff <= 1'b0;
    end else if (!nxt_tip) begin
      sout_ff <= 1'b0;
    end else if (fall) begin
      sout_ff <= (auto_m & ~txe) ? 1'b0 : shreg_ff[7];
    end
  end
  assign serial_out_line = sout_ff;

  // Shift register; bit order is swapped only on the way in and out, so the
  // order bit must be settled before a byte is written.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_ff <= 8'h00;
    end else if (wr_shd && !tip_ff) begin
      shreg_ff <= ord ? rev8(s_axi_wdata[7:0]) : s_axi_wdata[7:0];
    end else if (en && state_ff == ST_LOAD && !cpu_buf) begin
      shreg_ff <= ord ? rev8(mem[ptr_ff]) : mem[ptr_ff];
    end else if (rise) begin
      shreg_ff <= {shreg_ff[6:0], rxbit_ff};
    end
  end

  // Pointer steps after each stored byte and wraps at the end of the range;
  // an abort leaves it at the entry after the last byte stored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= `CSP_PTR_RST;
    end else if (en && state_ff == ST_STORE && !cpu_buf) begin
      ptr_ff <= (ptr_ff == end_ff) ? 5'h00 : ptr_ff + 5'h01;
    end
  end

  // Last-byte marker; in repeat mode the range never ends on its own.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ff <= 1'b0;
    end else if (start_auto || start_single) begin
      last_ff <= 1'b0;
    end else if (state_ff == ST_STORE && !cpu_buf) begin
      last_ff <= (ptr_ff == end_ff) & ~rpt;
    end
  end

  // Stop request; taken only while busy in auto mode, and cleared once busy drops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_ff <= 1'b0;
    end else if (wr_trig && s_axi_wdata[`CSP_B_STOP] && tip_ff && auto_m) begin
      stop_ff <= 1'b1;
    end else if (!tip_ff) begin
      stop_ff <= 1'b0;
    end
  end

  // Buffer RAM; the CPU write has priority over the sequencer's store.
  always_ff @(posedge clk) begin
    if (wr_buf) begin
      mem[s_axi_awaddr[6:2]] <= s_axi_wdata[7:0];
    end else if (en && state_ff == ST_STORE && rxe) begin
      mem[ptr_ff] <= ord ? rev8(shreg_ff) : shreg_ff;
    end
  end

  // Software registers. The interval is frozen while busy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= `CSP_MODE_RST;
      div_ff <= DIV_RST;
      end_ff <= `CSP_END_RST;
      gap_ff <= `CSP_GAP_RST;
    end else if (wr_lo) begin
      if (wword == `CSP_OFS_MODE) begin
        mode_ff <= s_axi_wdata[5:0];
      end
      if (wword == `CSP_OFS_DIV) begin
        div_ff <= s_axi_wdata[7:0];
      end
      if (wword == `CSP_OFS_END) begin
        end_ff <= s_axi_wdata[4:0];
      end
      if (wword == `CSP_OFS_GAP && !tip_ff) begin
        gap_ff <= s_axi_wdata[5:0];
      end
    end
  end

  // Write response; unmapped words answer with an error.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CSP_RESP_OK;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (s_axi_awaddr[7] || s_axi_awaddr[6:5] == 2'b00) ? `CSP_RESP_OK : `CSP_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data, registered one cycle after the address is taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `CSP_RESP_OK;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `CSP_RESP_OK;
      rdata_ff <= 32'h0000_0000;
      if (rd_buf) begin
        rdata_ff <= {24'h00_0000, mem[s_axi_araddr[6:2]]};
      end else begin
        case (rword)
          `CSP_OFS_MODE: rdata_ff <= {26'h000_0000, mode_ff};
          `CSP_OFS_STAT: rdata_ff <= {31'h0000_0000, tip_ff};
          `CSP_OFS_TRIG: rdata_ff <= 32'h0000_0000;
          `CSP_OFS_DIV: rdata_ff <= {24'h00_0000, div_ff};
          `CSP_OFS_END: rdata_ff <= {27'h000_0000, end_ff};
          `CSP_OFS_GAP: rdata_ff <= {26'h000_0000, gap_ff};
          `CSP_OFS_PTR: rdata_ff <= {27'h000_0000, ptr_ff};
          `CSP_OFS_SHD: rdata_ff <= {24'h00_0000, ord ? rev8(shreg_ff) : shreg_ff};
          default: rresp_ff <= `CSP_RESP_ERR;
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Helper: serial clock falls seen during the current byte.
  logic [3:0] fall_cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt_ff <= 4'h0;
    end else if (state_ff != ST_SHIFT) begin
      fall_cnt_ff <= 4'h0;
    end else if (fall) begin
      fall_cnt_ff <= fall_cnt_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sout_idle_low: assert property (!tip_ff |-> !serial_out_line)
    else $error("serial output high while idle");
  a_sck_idle_high: assert property (!tip_ff |-> serial_clock_line)
    else $error("serial clock low while idle");
  a_single_start: assert property (start_single |=> tip_ff && state_ff == ST_SHIFT)
    else $error("single write did not start a byte");
  a_late_enable: assert property ((wr_shd && !en) |=> !tip_ff)
    else $error("write while disabled started a transfer");
  a_irq_ends_busy: assert property (transfer_done_irq |-> !tip_ff && $past(tip_ff))
    else $error("done pulse without end of busy");
  a_abort_silent: assert property ((tip_ff && !en) |=> !tip_ff && !transfer_done_irq)
    else $error("disable raised done or left busy");
  a_byte_len: assert property ((state_ff == ST_SHIFT && en ##1 state_ff inside {ST_STORE, ST_GAP})
      |-> fall_cnt_ff == 4'h8)
    else $error("byte did not have eight clocks");
  a_ptr_step: assert property ((en && state_ff == ST_STORE && !cpu_buf && ptr_ff != end_ff)
      |=> ptr_ff == $past(ptr_ff) + 5'h01)
    else $error("pointer did not step");
  a_ptr_wrap: assert property ((en && state_ff == ST_STORE && !cpu_buf && ptr_ff == end_ff && rpt)
      |=> ptr_ff == 5'h00 && !last_ff)
    else $error("repeat did not wrap pointer");
  a_stop_ends: assert property ((stop_ff && en && state_ff == ST_GAP && gap_done)
      |=> !tip_ff && transfer_done_irq)
    else $error("stop did not end the sequence");

  c_single_done: cover property (start_single ##[1:300] transfer_done_irq);
  c_auto_done: cover property (start_auto ##[1:1000] transfer_done_irq);
  c_repeat_wrap: cover property (state_ff == ST_STORE && rpt && ptr_ff == end_ff && !cpu_buf);
  c_abort: cover property (tip_ff && !en);

endmodule : csp_serial_port

// file: csp_peer_model.sv
module csp_peer_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link, seen from the peripheral.
  input wire logic serial_clock_line,
  input wire logic serial_out_line,
  output logic serial_in_line,
  // One report per finished frame.
  output logic frame_done,
  output logic [7:0] got_byte,
  output logic [7:0] sent_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_ff;
  logic [2:0] cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] rep_ff;
  logic [7:0] nxt_rep;
  // The next reply bit waits on the line well before the fall, since the port synchronises it first.
  assign serial_in_line = tx_ff[7];
  assign nxt_rep = {rep_ff[6:0], rep_ff[7] ^ rep_ff[5] ^ rep_ff[4] ^ rep_ff[3]};
  // A fall is seen one clock late, when the port has already put out its bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_ff <= 1'b1;
      cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'hA5;
      rep_ff <= 8'hA5;
      frame_done <= 1'b0;
      got_byte <= 8'h00;
      sent_byte <= 8'h00;
    end else begin
      sck_ff <= serial_clock_line;
      frame_done <= 1'b0;
      if (sck_ff && !serial_clock_line) begin
        rx_ff <= {rx_ff[6:0], serial_out_line};
        tx_ff <= {tx_ff[6:0], 1'b0};
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == 3'h7) begin
          frame_done <= 1'b1;
          got_byte <= {rx_ff[6:0], serial_out_line};
          sent_byte <= rep_ff;
          rep_ff <= nxt_rep;
          tx_ff <= nxt_rep;
        end
      end
    end
  end
endmodule : csp_peer_model

// file: csp_serial_port_test.sv
`include "csp_defines.svh"
module csp_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck, sout, sin, irq, fdone;
  logic [7:0] awaddr, araddr, got, sent;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  int err_total, n_compared, irq_cnt, frames, gap_seen;
  time t_frame;
  logic [7:0] exp_wire[$], rx_log[$], tx_b[5];
  logic [33:0] exp_rd[$];
  logic [1:0] exp_b[$];

  csp_serial_port csp_serial_port_inst (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_line(sck), .serial_out_line(sout), .serial_in_line(sin), .transfer_done_irq(irq)
  );
  csp_peer_model csp_peer_model_inst (
    .clk(clk), .rst_n(rst_n), .serial_clock_line(sck), .serial_out_line(sout),
    .serial_in_line(sin), .frame_done(fdone), .got_byte(got), .sent_byte(sent)
  );

  // Free-running clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] rev(logic [7:0] v);
    return {<<{v}};
  endfunction : rev

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic cmp_word(string nm, logic [33:0] e, logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_range(string nm, int lo, int g);
    n_compared++;
    if (g < lo || g > lo + 4) begin
      err_total++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, lo + 4, g);
    end
  endtask : cmp_range

  task automatic stuck(string nm);
    err_total++;
    $display("BAD %s exp progress got timeout", nm);
    test_done();
  endtask : stuck

  function automatic logic sig(int s);
    case (s)
      0: return awready & wready;
      1: return bvalid;
      2: return arready;
      default: return rvalid;
    endcase
  endfunction : sig

  // Bounded wait for a handshake seen before an edge; returns just after that edge.
  task automatic wait_sig(int s);
    int i;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      if (sig(s) === 1'b1) break;
    end
    if (i == 50) stuck("handshake");
    @(posedge clk);
  endtask : wait_sig

  // Bounded wait on a bench counter; returns between edges.
  task automatic wait_cnt(string nm, ref int c, input int v);
    int i;
    for (i = 0; i < 5000 && c < v; i++) @(negedge clk);
    if (c < v) stuck(nm);
  endtask : wait_cnt

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = `CSP_RESP_OK);
    @(posedge clk);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_sig(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_sig(1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(logic [7:0] a, logic [33:0] e);
    @(posedge clk);
    exp_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_sig(2);
    arvalid <= 1'b0;
    wait_sig(3);
    rready <= 1'b0;
  endtask : axi_rd

  // Results are checked where they appear, against the oldest note; between edges avoids races.
  always @(negedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
      gap_seen = int'(($time - t_frame) / 4);
    end
    if (fdone === 1'b1) begin
      frames++;
      t_frame = $time;
      rx_log.push_back(sent);
      if (exp_wire.size() > 0) cmp_word("wire byte", {26'h0, exp_wire.pop_front()}, {26'h0, got});
      else cmp_word("extra frame", 34'h0, 34'h1);
    end
    if (rvalid === 1'b1 && rready === 1'b1) cmp_word("read", exp_rd.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) cmp_word("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
  end

  initial begin
    int k;
    int n;
    int fa;
    int fr;
    int p;
    logic [7:0] d;
    logic ord;
    rst_n = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'h31C76435;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then a word that no register owns.
    axi_rd(`CSP_OFS_MODE, 34'h0);
    axi_rd(`CSP_OFS_DIV, 34'h3);
    axi_rd(`CSP_OFS_PTR, 34'h0);
    axi_wr(8'h40, 32'h1, `CSP_RESP_ERR);
    // Data written before the enable must not start a frame.
    axi_wr(`CSP_OFS_SHD, 32'h5A);
    axi_wr(`CSP_OFS_MODE, 32'h1);
    repeat (100) @(posedge clk);
    axi_rd(`CSP_OFS_STAT, 34'h0);
    // Single bytes in both orders, repeat bit set, two gap lengths, a write while busy.
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      d = seed[7:0];
      ord = k[0];
      axi_wr(`CSP_OFS_MODE, {28'h0, ord, 3'h5});
      axi_wr(`CSP_OFS_GAP, {31'h0, k[1]});
      exp_wire.push_back(ord ? rev(d) : d);
      n = irq_cnt;
      axi_wr(`CSP_OFS_SHD, {24'h0, d});
      axi_wr(`CSP_OFS_SHD, {24'h0, ~d});
      axi_rd(`CSP_OFS_STAT, 34'h1);
      wait_cnt("done", irq_cnt, n + 1);
      cmp_range("done delay", 2 + 8 * k[1], gap_seen);
      cmp_word("idle out", 34'h0, {33'h0, sout});
      axi_rd(`CSP_OFS_STAT, 34'h0);
      d = rx_log[$];
      axi_rd(`CSP_OFS_SHD, {26'h0, ord ? rev(d) : d});
    end
    // Five bytes both ways through the buffer, with a CPU read racing the port.
    axi_wr(`CSP_OFS_MODE, 32'h0);
    for (k = 0; k < 5; k++) begin
      seed = xs(seed);
      tx_b[k] = seed[7:0];
      axi_wr(8'h80 + 8'(4 * k), {24'h0, tx_b[k]});
      exp_wire.push_back(tx_b[k]);
    end
    axi_wr(`CSP_OFS_END, 32'h4);
    axi_wr(`CSP_OFS_MODE, 32'h3);
    axi_wr(`CSP_OFS_MODE, 32'h33);
    axi_wr(`CSP_OFS_GAP, 32'h1);
    fa = frames;
    n = irq_cnt;
    axi_wr(`CSP_OFS_TRIG, 32'h1);
    axi_rd(8'h90, {26'h0, tx_b[4]});
    wait_cnt("auto", irq_cnt, n + 1);
    cmp_word("auto bytes", 34'h5, 34'(frames - fa));
    axi_rd(`CSP_OFS_PTR, 34'h0);
    axi_rd(`CSP_OFS_STAT, 34'h0);
    for (k = 0; k < 5; k++) axi_rd(8'h80 + 8'(4 * k), {26'h0, rx_log[fa + k]});
    // Three stored bytes sent over and over until a stop request.
    axi_wr(`CSP_OFS_END, 32'h2);
    axi_wr(`CSP_OFS_MODE, 32'h27);
    for (k = 0; k < 12; k++) exp_wire.push_back(rx_log[fa + k % 3]);
    fr = frames;
    n = irq_cnt;
    axi_wr(`CSP_OFS_TRIG, 32'h1);
    wait_cnt("repeat", frames, fr + 4);
    cmp_word("repeat done", 34'h0, 34'(irq_cnt - n));
    axi_wr(`CSP_OFS_TRIG, 32'h2);
    wait_cnt("stop", irq_cnt, n + 1);
    exp_wire.delete();
    p = (frames - fr) % 3;
    axi_rd(`CSP_OFS_PTR, 34'(p));
    axi_rd(`CSP_OFS_STAT, 34'h0);
    // Disable in mid-sequence: no completion event, pointer keeps its count.
    axi_wr(`CSP_OFS_END, 32'h4);
    axi_wr(`CSP_OFS_MODE, 32'h33);
    for (k = p; k < p + 2; k++) exp_wire.push_back(rx_log[fa + k]);
    fr = frames;
    n = irq_cnt;
    axi_wr(`CSP_OFS_TRIG, 32'h1);
    wait_cnt("abort", frames, fr + 2);
    repeat (8) @(posedge clk);
    axi_wr(`CSP_OFS_MODE, 32'h0);
    repeat (200) @(posedge clk);
    @(negedge clk);
    cmp_word("abort done", 34'h0, 34'(irq_cnt - n));
    cmp_word("abort lines", 34'h2, {32'h0, sck, sout});
    axi_rd(`CSP_OFS_STAT, 34'h0);
    axi_rd(`CSP_OFS_PTR, 34'(p + 2));
    test_done();
  end
endmodule : csp_serial_port_test
